/* core/cscs_cfg.svh */
// Offsets, field positions, codes and timing counts of the sequencer
`ifndef CSCS_CFG_SVH
`define CSCS_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CSCS_ADDR_CMD 8'h00
`define CSCS_ADDR_ARG 8'h04
`define CSCS_ADDR_MODE 8'h08
`define CSCS_ADDR_ERR 8'h0c
`define CSCS_ADDR_STAT 8'h10

// ****************************************************************
// Command word fields and opcodes
// ****************************************************************
`define CSCS_CMD_FLAG_BIT 4
`define CSCS_CMD_HASARG_BIT 5
`define CSCS_OP_MODE_SWITCH 4'h1
`define CSCS_OP_PASS_CHANGE 4'h2
`define CSCS_OP_CUR_SEL 4'h3
`define CSCS_OP_CUR_VAL 4'h4
`define CSCS_OP_MON_SEL 4'h5
`define CSCS_OP_VOLT_SEL 4'h6
`define CSCS_OP_VOLT_VAL 4'h7
`define CSCS_OP_SAVE 4'h8
`define CSCS_OP_OV_CAL 4'h9
`define CSCS_OP_INST_RESET 4'ha

// ****************************************************************
// Error codes and storage selectors
// ****************************************************************
`define CSCS_ERR_NONE 3'h0
`define CSCS_ERR_PASSWORD 3'h2
`define CSCS_ERR_NOT_ENABLED 3'h3
`define CSCS_ERR_SEQUENCE 3'h6
`define CSCS_ERR_REG_STATE 3'h7
`define CSCS_NV_PASS 3'h0
`define CSCS_NV_VOLT 3'h1
`define CSCS_NV_CURR 3'h2
`define CSCS_NV_MON 3'h3
`define CSCS_NV_OV 3'h4

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define CSCS_PASS_DEFAULT 16'h1234
`define CSCS_CLK_MHZ 250
`define CSCS_OV_CAL_MS 3000
`define CSCS_OV_CAL_CYCLES (32'd`CSCS_OV_CAL_MS * 32'd1000 * 32'd`CSCS_CLK_MHZ)

`endif

/* core/cscs_pkg.sv */
// Types shared by the calibration command sequencer
`default_nettype none
package cscs_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SAVE_V = 5'b00010,
    ST_SAVE_C = 5'b00100,
    ST_SAVE_M = 5'b01000,
    ST_OV = 5'b10000
  } cscs_state_e;

  typedef enum logic [3:0] {
    SQ_NONE = 4'b0001,
    SQ_LO_SEL = 4'b0010,
    SQ_LO_DONE = 4'b0100,
    SQ_HI_SEL = 4'b1000
  } cscs_seq_e;

  typedef logic [3:0] cscs_op_t;
endpackage : cscs_pkg
`default_nettype wire

/* core/cscs_timer_if.sv */
// Start and done handshake between sequencer and trip timer
`default_nettype none
interface cscs_timer_if;
  logic start;
  logic done;
  modport ctl (output start, input done);
  modport tmr (input start, output done);
endinterface : cscs_timer_if
`default_nettype wire

/* core/cscs_sync.sv */
// Two-flop synchroniser for one pin level
`default_nettype none
module cscs_sync (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb
  begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule : cscs_sync
`default_nettype wire

/* core/cscs_timer.sv */
// Self-timed run of the overvoltage trip calibration
`default_nettype none
module cscs_timer #(
  parameter logic [31:0] CYCLES = 32'd16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  cscs_timer_if.tmr tif
);
  logic [31:0] count;
  logic busy;
  logic done;
  logic [31:0] next_count;
  logic next_busy;
  logic next_done;

  assign tif.done = done;

  always_comb
  begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (tif.start)
    begin
      next_count = CYCLES - 32'd1;
      next_busy = 1'b1;
    end
    else if (busy && count == 32'd0)
    begin
      next_busy = 1'b0;
      next_done = 1'b1;
    end
    else if (busy)
      next_count = count - 32'd1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      count <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

  // Done only after a running count
  timer_done_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    done |-> $past(busy) && !busy)
    else $error("trip timer done without a run");
endmodule : cscs_timer
`default_nettype wire

/* core/cscs_top.sv */
// Calibration command sequencer with register port and storage port
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`include "cscs_cfg.svh"
`default_nettype none

// What this block does
// - Monitor point select puts the current entry on the monitor point.
// - Password change accepted only while calibration mode is enabled.
// - Stored password defaults to a fixed four-digit model value.
// - Zero password lets mode enable succeed without an argument.
// - New password goes to nonvolatile storage at once.
// - Save writes completed calibration constants to nonvolatile storage.
// - Every command but the mode switch and instrument reset is rejected while disabled.
// - Missing or wrong password with nonzero store flags error, stays off.
// - Mode query returns only the mode bit, never the password.
// - Leaving calibration mode discards unsaved constants.
// - Both voltage points entered gives volatile voltage constants.
// - Trip calibration runs by itself and stores its constant directly.
// - Trip calibration takes seconds; commands written meanwhile are ignored.
// - Password mismatch reports error code 2.
// - Command while mode is disabled reports error code 3.
// - Out-of-order point selection or entry reports error code 6.
// - Wrong regulation state for a command reports error code 7.
module cscs_top #(
  parameter logic [31:0] OV_CAL_CYCLES = `CSCS_OV_CAL_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic cv_i,
  input wire logic cc_i,
  input wire logic [15:0] ov_level_i,
  output logic nv_wr_o,
  output logic [2:0] nv_sel_o,
  output logic [31:0] nv_data_o,
  output logic cal_mode_o,
  output logic busy_o
);
  // ****************************************************************
  // Pin synchronisers and trip timer
  // ****************************************************************
  logic cv_s;
  logic cc_s;
  cscs_timer_if tif ();

  cscs_sync u_sync_cv (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(cv_i),
    .q_o(cv_s)
  );

  cscs_sync u_sync_cc (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(cc_i),
    .q_o(cc_s)
  );

  cscs_timer #(.CYCLES(OV_CAL_CYCLES)) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tif(tif.tmr)
  );

  // ****************************************************************
  // Command state
  // ****************************************************************
  cscs_pkg::cscs_state_e state, next_state;
  cscs_pkg::cscs_seq_e vseq, next_vseq, cseq, next_cseq;
  cscs_pkg::cscs_op_t op;
  logic mode, next_mode;
  logic [15:0] pw, next_pw;
  logic [15:0] arg, next_arg;
  logic [15:0] vlo, next_vlo, vhi, next_vhi;
  logic [15:0] clo, next_clo, chi, next_chi, mon, next_mon;
  logic vpend, next_vpend, cpend, next_cpend, mpend, next_mpend;
  logic cur_mon, next_cur_mon;
  logic tstart, next_tstart;
  logic next_nv_wr;
  logic [2:0] next_nv_sel;
  logic [31:0] next_nv_data;
  logic [2:0] err_ev;
  logic cmd_go, flag, has_arg;

  assign op = cscs_pkg::cscs_op_t'(wdata_i[3:0]);
  assign flag = wdata_i[`CSCS_CMD_FLAG_BIT];
  assign has_arg = wdata_i[`CSCS_CMD_HASARG_BIT];
  assign cmd_go = wr_i && addr_i == `CSCS_ADDR_CMD
    && state == cscs_pkg::ST_IDLE;
  assign tif.start = tstart;

  always_comb
  begin
    next_state = state;
    next_vseq = vseq;
    next_cseq = cseq;
    next_mode = mode;
    next_pw = pw;
    next_arg = arg;
    next_vlo = vlo;
    next_vhi = vhi;
    next_clo = clo;
    next_chi = chi;
    next_mon = mon;
    next_vpend = vpend;
    next_cpend = cpend;
    next_mpend = mpend;
    next_cur_mon = cur_mon;
    next_tstart = 1'b0;
    next_nv_wr = 1'b0;
    next_nv_sel = `CSCS_NV_PASS;
    next_nv_data = 32'h0;
    err_ev = `CSCS_ERR_NONE;
    if (wr_i && addr_i == `CSCS_ADDR_ARG)
      next_arg = wdata_i[15:0];
    case (state)
      cscs_pkg::ST_IDLE:
      begin
        if (!cmd_go)
          next_state = cscs_pkg::ST_IDLE;
        else if (op == `CSCS_OP_INST_RESET)
          next_mode = 1'b0;
        else if (op == `CSCS_OP_MODE_SWITCH)
        begin
          if (!flag)
            next_mode = 1'b0;
          else if (pw == 16'h0)
            next_mode = 1'b1;
          else if (!has_arg || arg != pw)
            err_ev = `CSCS_ERR_PASSWORD;
          else
            next_mode = 1'b1;
        end
        else if (!mode)
        begin
          if (op >= `CSCS_OP_PASS_CHANGE && op <= `CSCS_OP_OV_CAL)
            err_ev = `CSCS_ERR_NOT_ENABLED;
        end
        else
        begin
          case (op)
            `CSCS_OP_PASS_CHANGE:
            begin
              next_pw = arg;
              next_nv_wr = 1'b1;
              next_nv_sel = `CSCS_NV_PASS;
              next_nv_data = {16'h0, arg};
            end
            `CSCS_OP_CUR_SEL:
            begin
              next_cur_mon = 1'b0;
              if (!flag)
                next_cseq = cscs_pkg::SQ_LO_SEL;
              else if (cseq == cscs_pkg::SQ_LO_DONE)
                next_cseq = cscs_pkg::SQ_HI_SEL;
              else
                err_ev = `CSCS_ERR_SEQUENCE;
            end
            `CSCS_OP_CUR_VAL:
            begin
              if (cur_mon)
              begin
                next_mon = arg;
                next_mpend = 1'b1;
                next_cpend = 1'b0;
                next_cur_mon = 1'b0;
              end
              else if (cseq == cscs_pkg::SQ_LO_SEL)
              begin
                next_clo = arg;
                next_cseq = cscs_pkg::SQ_LO_DONE;
              end
              else if (cseq == cscs_pkg::SQ_HI_SEL)
              begin
                next_chi = arg;
                next_cpend = 1'b1;
                next_cseq = cscs_pkg::SQ_NONE;
              end
              else
                err_ev = `CSCS_ERR_SEQUENCE;
            end
            `CSCS_OP_MON_SEL:
            begin
              if (!cc_s)
                err_ev = `CSCS_ERR_REG_STATE;
              else
              begin
                next_cur_mon = 1'b1;
                next_cseq = cscs_pkg::SQ_NONE;
              end
            end
            `CSCS_OP_VOLT_SEL:
            begin
              if (!flag)
                next_vseq = cscs_pkg::SQ_LO_SEL;
              else if (vseq == cscs_pkg::SQ_LO_DONE)
                next_vseq = cscs_pkg::SQ_HI_SEL;
              else
                err_ev = `CSCS_ERR_SEQUENCE;
            end
            `CSCS_OP_VOLT_VAL:
            begin
              if (vseq == cscs_pkg::SQ_LO_SEL)
              begin
                next_vlo = arg;
                next_vseq = cscs_pkg::SQ_LO_DONE;
              end
              else if (vseq == cscs_pkg::SQ_HI_SEL)
              begin
                next_vhi = arg;
                next_vpend = 1'b1;
                next_vseq = cscs_pkg::SQ_NONE;
              end
              else
                err_ev = `CSCS_ERR_SEQUENCE;
            end
            `CSCS_OP_SAVE:
              next_state = cscs_pkg::ST_SAVE_V;
            `CSCS_OP_OV_CAL:
            begin
              if (!cv_s)
                err_ev = `CSCS_ERR_REG_STATE;
              else
              begin
                next_tstart = 1'b1;
                next_state = cscs_pkg::ST_OV;
              end
            end
            default:
              next_state = cscs_pkg::ST_IDLE;
          endcase
        end
      end
      cscs_pkg::ST_SAVE_V:
      begin
        next_nv_wr = vpend;
        next_nv_sel = `CSCS_NV_VOLT;
        next_nv_data = {vhi, vlo};
        next_vpend = 1'b0;
        next_state = cscs_pkg::ST_SAVE_C;
      end
      cscs_pkg::ST_SAVE_C:
      begin
        next_nv_wr = cpend;
        next_nv_sel = `CSCS_NV_CURR;
        next_nv_data = {chi, clo};
        next_cpend = 1'b0;
        next_state = cscs_pkg::ST_SAVE_M;
      end
      cscs_pkg::ST_SAVE_M:
      begin
        next_nv_wr = mpend;
        next_nv_sel = `CSCS_NV_MON;
        next_nv_data = {16'h0, mon};
        next_mpend = 1'b0;
        next_state = cscs_pkg::ST_IDLE;
      end
      cscs_pkg::ST_OV:
      begin
        if (tif.done)
        begin
          next_nv_wr = 1'b1;
          next_nv_sel = `CSCS_NV_OV;
          next_nv_data = {16'h0, ov_level_i};
          next_state = cscs_pkg::ST_IDLE;
        end
      end
      default:
        next_state = cscs_pkg::ST_IDLE;
    endcase
    if (!next_mode)
    begin
      next_vpend = 1'b0;
      next_cpend = 1'b0;
      next_mpend = 1'b0;
      next_cur_mon = 1'b0;
      next_vseq = cscs_pkg::SQ_NONE;
      next_cseq = cscs_pkg::SQ_NONE;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= cscs_pkg::ST_IDLE;
      vseq <= cscs_pkg::SQ_NONE;
      cseq <= cscs_pkg::SQ_NONE;
      mode <= 1'b0;
      pw <= `CSCS_PASS_DEFAULT;
      arg <= 16'h0;
      vlo <= 16'h0;
      vhi <= 16'h0;
      clo <= 16'h0;
      chi <= 16'h0;
      mon <= 16'h0;
      vpend <= 1'b0;
      cpend <= 1'b0;
      mpend <= 1'b0;
      cur_mon <= 1'b0;
      tstart <= 1'b0;
      nv_wr_o <= 1'b0;
      nv_sel_o <= `CSCS_NV_PASS;
      nv_data_o <= 32'h0;
    end
    else
    begin
      state <= next_state;
      vseq <= next_vseq;
      cseq <= next_cseq;
      mode <= next_mode;
      pw <= next_pw;
      arg <= next_arg;
      vlo <= next_vlo;
      vhi <= next_vhi;
      clo <= next_clo;
      chi <= next_chi;
      mon <= next_mon;
      vpend <= next_vpend;
      cpend <= next_cpend;
      mpend <= next_mpend;
      cur_mon <= next_cur_mon;
      tstart <= next_tstart;
      nv_wr_o <= next_nv_wr;
      nv_sel_o <= next_nv_sel;
      nv_data_o <= next_nv_data;
    end
  end

  // ****************************************************************
  // Register read port and error code
  // ****************************************************************
  logic [2:0] err, next_err;
  logic [31:0] next_rdata;
  logic next_busy;

  always_comb
  begin
    next_rdata = 32'h0;
    next_busy = next_state != cscs_pkg::ST_IDLE;
    if (rd_i)
    begin
      case (addr_i)
        `CSCS_ADDR_ARG: next_rdata = {16'h0, arg};
        `CSCS_ADDR_MODE: next_rdata = {31'h0, mode};
        `CSCS_ADDR_ERR: next_rdata = {29'h0, err};
        `CSCS_ADDR_STAT: next_rdata = {25'h0, cc_s, cv_s, cur_mon,
          mpend, cpend, vpend, state != cscs_pkg::ST_IDLE};
        default: next_rdata = 32'h0;
      endcase
    end
    // New error wins over read clear
    if (err_ev != `CSCS_ERR_NONE)
      next_err = err_ev;
    else if (rd_i && addr_i == `CSCS_ADDR_ERR)
      next_err = `CSCS_ERR_NONE;
    else
      next_err = err;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      err <= `CSCS_ERR_NONE;
      rdata_o <= 32'h0;
      cal_mode_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      err <= next_err;
      rdata_o <= next_rdata;
      cal_mode_o <= next_mode;
      busy_o <= next_busy;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  mode_query_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == `CSCS_ADDR_MODE |=> rdata_o == {31'h0, mode})
    else $error("mode query shows more than the mode");
  pass_gate_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && op == `CSCS_OP_PASS_CHANGE && !mode |=> $stable(pw))
    else $error("password changed while disabled");
  zero_pass_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && op == `CSCS_OP_MODE_SWITCH && flag && pw == 16'h0
    |=> mode && $stable(err))
    else $error("zero password did not open mode");
  bad_pass_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && op == `CSCS_OP_MODE_SWITCH && flag && pw != 16'h0
    && !has_arg && !mode |=> !mode && err == `CSCS_ERR_PASSWORD)
    else $error("missing password accepted");
  gate_cmd_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && !mode && op == `CSCS_OP_SAVE
    |=> err == `CSCS_ERR_NOT_ENABLED && state == cscs_pkg::ST_IDLE)
    else $error("command taken while disabled");
  pass_store_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && mode && op == `CSCS_OP_PASS_CHANGE
    |=> nv_wr_o && nv_sel_o == `CSCS_NV_PASS && nv_data_o[15:0] == pw)
    else $error("password not stored at once");
  discard_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(mode) |-> !vpend && !cpend && !mpend)
    else $error("unsaved constants kept after disable");
  seq_err_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && mode && op == `CSCS_OP_VOLT_VAL
    && vseq == cscs_pkg::SQ_NONE |=> err == `CSCS_ERR_SEQUENCE)
    else $error("entry without point accepted");
  state_err_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && mode && op == `CSCS_OP_OV_CAL && !cv_s
    |=> err == `CSCS_ERR_REG_STATE && state == cscs_pkg::ST_IDLE)
    else $error("trip run without CV");
  volt_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && mode && op == `CSCS_OP_VOLT_VAL
    && vseq == cscs_pkg::SQ_HI_SEL |=> vpend && !nv_wr_o)
    else $error("voltage constants not held volatile");
  save_volt_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    state == cscs_pkg::ST_SAVE_V && vpend
    |=> nv_wr_o && nv_sel_o == `CSCS_NV_VOLT ##1 !vpend)
    else $error("save skipped voltage constants");
  ov_store_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    state == cscs_pkg::ST_OV && tif.done
    |=> nv_wr_o && nv_sel_o == `CSCS_NV_OV && state == cscs_pkg::ST_IDLE)
    else $error("trip constant not stored");
  reset_mode_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_go && op == `CSCS_OP_INST_RESET |=> !mode && !cal_mode_o)
    else $error("instrument reset left mode on");
endmodule : cscs_top
`default_nettype wire

/* tb/cscs_nv_model.sv */
// Nonvolatile storage model on the storage port of the sequencer
`default_nettype none
module cscs_nv_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic nv_wr_i,
  input wire logic [2:0] nv_sel_i,
  input wire logic [31:0] nv_data_i,
  output logic [2:0] last_sel_o,
  output logic [31:0] last_data_o,
  output logic [7:0] count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      last_sel_o <= 3'h0;
      last_data_o <= 32'h0;
      count_o <= 8'h00;
    end
    else if (nv_wr_i)
    begin
      last_sel_o <= nv_sel_i;
      last_data_o <= nv_data_i;
      count_o <= count_o + 8'h01;
    end
  end
endmodule : cscs_nv_model
`default_nettype wire

/* tb/tb_calibration_command_sequencer.sv */
// Self-checking bench of the calibration command sequencer
`include "cscs_cfg.svh"
`default_nettype none
module tb_calibration_command_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic cv_i = 1'b0;
  logic cc_i = 1'b0;
  logic [15:0] ov_level_i = 16'h0abc;
  logic [31:0] rdata_o;
  logic [31:0] nv_data_o;
  logic [31:0] nv_last_data;
  logic nv_wr_o;
  logic cal_mode_o;
  logic busy_o;
  logic [2:0] nv_sel_o;
  logic [2:0] nv_last_sel;
  logic [7:0] nv_count;
  logic [31:0] rv;
  int n_mismatch = 0;
  int samples_checked = 0;
  int i;

  always #2 sys_clk_i = ~sys_clk_i;

  cscs_top #(.OV_CAL_CYCLES(32'd20)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cv_i(cv_i), .cc_i(cc_i), .ov_level_i(ov_level_i),
    .nv_wr_o(nv_wr_o), .nv_sel_o(nv_sel_o), .nv_data_o(nv_data_o),
    .cal_mode_o(cal_mode_o), .busy_o(busy_o)
  );

  cscs_nv_model i_nv (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .nv_wr_i(nv_wr_o),
    .nv_sel_i(nv_sel_o), .nv_data_i(nv_data_o),
    .last_sel_o(nv_last_sel), .last_data_o(nv_last_data),
    .count_o(nv_count)
  );

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o & m, exp);
  endtask : rchk

  task automatic cmd(input logic [15:0] arg, input logic [5:0] op);
    wr(`CSCS_ADDR_ARG, {16'h0, arg});
    wr(`CSCS_ADDR_CMD, {26'h0, op});
  endtask : cmd

  task automatic vseq(input logic [15:0] lo, input logic [15:0] hi);
    cmd(16'h0, 6'h06);
    cmd(lo, 6'h07);
    cmd(16'h0, 6'h16);
    cmd(hi, 6'h07);
  endtask : vseq

  task automatic nvchk(input logic [2:0] s, input logic [31:0] d,
    input logic [7:0] n);
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk({29'h0, nv_last_sel}, {29'h0, s});
    chk(nv_last_data, d);
    chk({24'h0, nv_count}, {24'h0, n});
  endtask : nvchk

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk({31'h0, cal_mode_o}, 32'h0);
    cmd(16'h5678, 6'h02);
    rchk(`CSCS_ADDR_ERR, 32'h7, 32'h3);
    cmd(16'h4321, 6'h31);
    rchk(`CSCS_ADDR_ERR, 32'h7, 32'h2);
    rchk(`CSCS_ADDR_MODE, 32'hffffffff, 32'h0);
    cmd(16'h0, 6'h11);
    rchk(`CSCS_ADDR_ERR, 32'h7, 32'h2);
    for (i = 3; i < 10; i++)
    begin
      cmd(16'h0, i[5:0]);
      rchk(`CSCS_ADDR_ERR, 32'h7, 32'h3);
    end
    chk({24'h0, nv_count}, 32'h0);
    cmd(16'h1234, 6'h31);
    rchk(`CSCS_ADDR_MODE, 32'hffffffff, 32'h1);
    $display("test mode gating done");
    cmd(16'h0, 6'h16);
    rchk(`CSCS_ADDR_ERR, 32'h7, 32'h6);
    cmd(16'h0011, 6'h07);
    rchk(`CSCS_ADDR_ERR, 32'h7, 32'h6);
    vseq(16'h0011, 16'h0022);
    rchk(`CSCS_ADDR_STAT, 32'h2, 32'h2);
    chk({24'h0, nv_count}, 32'h0);
    cmd(16'h0, 6'h08);
    nvchk(3'h1, 32'h00220011, 8'h01);
    rchk(`CSCS_ADDR_STAT, 32'h2, 32'h0);
    $display("test voltage points done");
    cmd(16'h0, 6'h05);
    rchk(`CSCS_ADDR_ERR, 32'h7, 32'h7);
    @(posedge sys_clk_i) cc_i <= 1'b1;
    cmd(16'h0, 6'h03);
    cmd(16'h0033, 6'h04);
    cmd(16'h0, 6'h13);
    cmd(16'h0044, 6'h04);
    rchk(`CSCS_ADDR_STAT, 32'h4, 32'h4);
    cmd(16'h0, 6'h05);
    rchk(`CSCS_ADDR_STAT, 32'h10, 32'h10);
    cmd(16'h0055, 6'h04);
    rchk(`CSCS_ADDR_STAT, 32'hc, 32'h8);
    cmd(16'h0, 6'h08);
    nvchk(3'h3, 32'h00000055, 8'h02);
    cmd(16'h0, 6'h03);
    cmd(16'h0066, 6'h04);
    cmd(16'h0, 6'h13);
    cmd(16'h0077, 6'h04);
    cmd(16'h0, 6'h08);
    nvchk(3'h2, 32'h00770066, 8'h03);
    $display("test monitor point done");
    vseq(16'h0001, 16'h0002);
    cmd(16'h0, 6'h01);
    cmd(16'h1234, 6'h31);
    rchk(`CSCS_ADDR_STAT, 32'h2, 32'h0);
    cmd(16'h0, 6'h08);
    nvchk(3'h2, 32'h00770066, 8'h03);
    cmd(16'h0, 6'h02);
    nvchk(3'h0, 32'h0, 8'h04);
    cmd(16'h0, 6'h01);
    cmd(16'h0, 6'h11);
    rchk(`CSCS_ADDR_MODE, 32'hffffffff, 32'h1);
    $display("test password done");
    @(posedge sys_clk_i) cc_i <= 1'b0;
    cmd(16'h0, 6'h09);
    rchk(`CSCS_ADDR_ERR, 32'h7, 32'h7);
    @(posedge sys_clk_i) cv_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    cmd(16'h0, 6'h09);
    rchk(`CSCS_ADDR_STAT, 32'h1, 32'h1);
    chk({31'h0, busy_o}, 32'h1);
    cmd(16'h0, 6'h01);
    i = 0;
    while (busy_o !== 1'b0 && i < 200)
    begin
      @(posedge sys_clk_i);
      #1;
      i++;
    end
    nvchk(3'h4, {16'h0, ov_level_i}, 8'h05);
    rchk(`CSCS_ADDR_MODE, 32'hffffffff, 32'h1);
    $display("test trip run done");
    cmd(16'h0, 6'h0a);
    rchk(`CSCS_ADDR_MODE, 32'hffffffff, 32'h0);
    chk({31'h0, cal_mode_o}, 32'h0);
    rchk(8'h20, 32'hffffffff, 32'h0);
    $display("test reset and map done");
    end_of_test();
  end

  initial
  begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_calibration_command_sequencer
`default_nettype wire
